// ### hdl/timer8_map.svh
// Register offsets, field positions and reset values of the eight-bit timer front end.
`ifndef TIMER8_MAP_SVH
`define TIMER8_MAP_SVH
`define TIMER_BANK_D 4'hD
`define TIMER_OFS_CONTROL 4'h0
`define TIMER_OFS_LOW_HOLD 4'h4
`define TIMER_OFS_HIGH_HOLD 4'h5
`define TIMER_OFS_WIDE_LOW 4'h6
`define TIMER_BIT_RUN 7
`define TIMER_BIT_SINGLE 6
`define TIMER_BIT_TIMEOUT 5
`define TIMER_BIT_CLK_HI 4
`define TIMER_BIT_CLK_LO 3
`define TIMER_BIT_CAP_IE 2
`define TIMER_BIT_TO_IE 1
`define TIMER_CONTROL_RESET 8'h00
`define TIMER_HOLD_RESET 8'h00
`define TIMER_COUNT_ALL_ONES 8'hFF
`endif

// ### hdl/timer8_pkg.sv
// Types shared by the eight-bit timer front end.
package timer8_pkg;
    typedef struct packed {
        logic run;
        logic single;
        logic [1:0] prescale_select;
        logic cap_ie;
        logic to_ie;
    } control_s;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] bank;
        logic [3:0] index;
        logic [7:0] data;
    } reg_req_s;
endpackage

// ### hdl/timer8_prescaler.sv
// Count clock enable divider for the eight-bit timer.
`timescale 1ns/1ns
module timer8_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [1:0] prescale_select_i,
    output logic tick_o
);
    logic [2:0] div_count;
    logic [2:0] div_mask;

    always_comb begin
        div_mask = 3'h0;
        unique case (prescale_select_i)
            2'h0: div_mask = 3'h0;
            2'h1: div_mask = 3'h1;
            2'h2: div_mask = 3'h3;
            2'h3: div_mask = 3'h7;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            div_count <= 3'h0;
        end else begin
            div_count <= div_count + 3'h1;
        end
    end

    // Tick once every 1, 2, 4 or 8 system clocks.
    assign tick_o = run_i && ((div_count & div_mask) == div_mask);
endmodule

// ### hdl/timer8_ctrl.sv
// Control and hold registers with the eight-bit down counter.
// How it works
// - Control bit 7 written 1 starts the counter, written 0 stops it, and resets to 0.
// - Control bit 6 picks repeating modulo-N (0, reset) or single pass (1).
// - Control bit 5 reads 1 once a time-out has happened, 0 otherwise, and resets to 0.
// - Writing 1 to bit 5 clears the time-out flag, writing 0 leaves it.
// - Bits 4:3 divide the count clock by 1, 2, 4 or 8, with 1 after reset.
// - Bit 2 gates the data-capture interrupt and resets to 0.
// - The high hold register is a read/write byte at offset 05H of bank D.
// - The low hold register is a read/write byte at offset 04H of bank D.
// - The wide counter low hold byte is a read/write byte at offset 06H of bank D.
// - The control register is decoded at offset 00H of bank D.
// - Registers are addressed as one of sixteen banks of sixteen registers.
// - With bit 2 set, a capture event raises a capture interrupt request.
// - Reaching zero sets the time-out flag and interrupts only when bit 1 is set.
// - After a time-out in capture operation counting resumes from all ones.
`timescale 1ns/1ns
`include "timer8_map.svh"
module timer8_ctrl (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [3:0] REG_BANK_I,
    input wire logic [3:0] REG_INDEX_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic CAPTURE_MODE_I,
    input wire logic CAPTURE_EVENT_I,
    output logic [7:0] REG_RDATA_O,
    output logic [7:0] COUNT_O,
    output logic TIMEOUT_IRQ_O,
    output logic CAPTURE_IRQ_O,
    output logic RUNNING_O
);
    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    timer8_pkg::reg_req_s req;
    timer8_pkg::control_s ctl;
    logic timeout_flag;
    logic [7:0] low_hold;
    logic [7:0] high_hold;
    logic [7:0] wide_low_hold;
    logic [7:0] count;
    logic phase_high;
    logic tick;
    logic in_bank;
    logic wr_ctl;
    logic terminal;
    logic [7:0] next_rdata;

    assign req = '{wr: REG_WR_I, rd: REG_RD_I, bank: REG_BANK_I,
                   index: REG_INDEX_I, data: REG_WDATA_I};
    assign in_bank = (req.bank == `TIMER_BANK_D);
    assign wr_ctl = req.wr && in_bank && (req.index == `TIMER_OFS_CONTROL);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctl <= '0;
        end else if (wr_ctl) begin
            ctl.run <= req.data[`TIMER_BIT_RUN];
            ctl.single <= req.data[`TIMER_BIT_SINGLE];
            ctl.prescale_select <= req.data[`TIMER_BIT_CLK_HI:`TIMER_BIT_CLK_LO];
            ctl.cap_ie <= req.data[`TIMER_BIT_CAP_IE];
            ctl.to_ie <= req.data[`TIMER_BIT_TO_IE];
        end else if (terminal && ctl.single && !CAPTURE_MODE_I) begin
            ctl.run <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            low_hold <= `TIMER_HOLD_RESET;
            high_hold <= `TIMER_HOLD_RESET;
            wide_low_hold <= `TIMER_HOLD_RESET;
        end else if (req.wr && in_bank) begin
            if (req.index == `TIMER_OFS_LOW_HOLD) begin
                low_hold <= req.data;
            end
            if (req.index == `TIMER_OFS_HIGH_HOLD) begin
                high_hold <= req.data;
            end
            if (req.index == `TIMER_OFS_WIDE_LOW) begin
                wide_low_hold <= req.data;
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (in_bank) begin
            unique case (req.index)
                `TIMER_OFS_CONTROL: next_rdata = {ctl.run, ctl.single, timeout_flag,
                                               ctl.prescale_select, ctl.cap_ie,
                                               ctl.to_ie, 1'b0};
                `TIMER_OFS_LOW_HOLD: next_rdata = low_hold;
                `TIMER_OFS_HIGH_HOLD: next_rdata = high_hold;
                `TIMER_OFS_WIDE_LOW: next_rdata = wide_low_hold;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            REG_RDATA_O <= 8'h00;
        end else if (req.rd) begin
            REG_RDATA_O <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    timer8_prescaler u_prescaler (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .run_i(ctl.run),
        .prescale_select_i(ctl.prescale_select),
        .tick_o(tick)
    );

    assign terminal = tick && (count == 8'h00);

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            count <= 8'h00;
            phase_high <= 1'b0;
        end else if (wr_ctl && req.data[`TIMER_BIT_RUN] && !ctl.run) begin
            count <= low_hold;
            phase_high <= 1'b0;
        end else if (CAPTURE_MODE_I && CAPTURE_EVENT_I && ctl.run) begin
            count <= `TIMER_COUNT_ALL_ONES;
        end else if (terminal) begin
            if (CAPTURE_MODE_I) begin
                count <= `TIMER_COUNT_ALL_ONES;
            end else if (!ctl.single) begin
                count <= phase_high ? low_hold : high_hold;
                phase_high <= !phase_high;
            end
        end else if (tick) begin
            count <= count - 8'h01;
        end
    end

    // Set wins over a software clear in the same cycle.
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            timeout_flag <= 1'b0;
        end else if (terminal) begin
            timeout_flag <= 1'b1;
        end else if (wr_ctl && req.data[`TIMER_BIT_TIMEOUT]) begin
            timeout_flag <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            TIMEOUT_IRQ_O <= 1'b0;
            CAPTURE_IRQ_O <= 1'b0;
            COUNT_O <= 8'h00;
            RUNNING_O <= 1'b0;
        end else begin
            TIMEOUT_IRQ_O <= terminal && ctl.to_ie;
            CAPTURE_IRQ_O <= CAPTURE_EVENT_I && ctl.cap_ie;
            COUNT_O <= count;
            RUNNING_O <= ctl.run;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_run_bit_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        wr_ctl |=> ctl.run == $past(req.data[7]))
        else $error("run bit not taken from write");
    a_single_write: assert property (@(posedge CLK_I) disable iff (RST_I)
        wr_ctl |=> ctl.single == $past(req.data[6]))
        else $error("single pass bit not taken from write");
    a_timeout_sets: assert property (@(posedge CLK_I) disable iff (RST_I)
        terminal |=> timeout_flag)
        else $error("time-out flag not set at zero");
    a_timeout_clear: assert property (@(posedge CLK_I) disable iff (RST_I)
        (wr_ctl && req.data[5] && !terminal) |=> !timeout_flag)
        else $error("time-out flag not cleared");
    a_timeout_keep: assert property (@(posedge CLK_I) disable iff (RST_I)
        (wr_ctl && !req.data[5] && timeout_flag) |=> timeout_flag)
        else $error("time-out flag lost on zero write");
    a_capture_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
        CAPTURE_IRQ_O |-> $past(ctl.cap_ie) && $past(CAPTURE_EVENT_I))
        else $error("capture interrupt while masked");
    a_timeout_gate: assert property (@(posedge CLK_I) disable iff (RST_I)
        TIMEOUT_IRQ_O |-> $past(ctl.to_ie) && $past(terminal))
        else $error("time-out interrupt while masked");
    a_high_hold_rw: assert property (@(posedge CLK_I) disable iff (RST_I)
        (req.wr && in_bank && req.index == 4'h5) |=> high_hold == $past(req.data))
        else $error("high hold write lost");
    a_low_hold_rw: assert property (@(posedge CLK_I) disable iff (RST_I)
        (req.wr && in_bank && req.index == 4'h4) |=> low_hold == $past(req.data))
        else $error("low hold write lost");
    a_wide_hold_rw: assert property (@(posedge CLK_I) disable iff (RST_I)
        (req.wr && in_bank && req.index == 4'h6) |=> wide_low_hold == $past(req.data))
        else $error("wide low hold write lost");
    a_ctl_readback: assert property (@(posedge CLK_I) disable iff (RST_I)
        (req.rd && in_bank && req.index == 4'h0 && !wr_ctl) |=>
        REG_RDATA_O[7] == $past(ctl.run))
        else $error("control read does not show run bit");
    a_bank_decode: assert property (@(posedge CLK_I) disable iff (RST_I)
        (req.rd && !in_bank) |=> REG_RDATA_O == 8'h00)
        else $error("other bank not read as zero");
    a_capture_reload: assert property (@(posedge CLK_I) disable iff (RST_I)
        (terminal && CAPTURE_MODE_I && !wr_ctl) |=> count == 8'hFF)
        else $error("capture counting not resumed from all ones");
    a_single_stops: assert property (@(posedge CLK_I) disable iff (RST_I)
        (terminal && ctl.single && !CAPTURE_MODE_I && !wr_ctl) |=> !ctl.run)
        else $error("single pass did not stop");
    a_prescale_rate: assert property (@(posedge CLK_I) disable iff (RST_I)
        (tick && ctl.prescale_select == 2'h3 && !wr_ctl) |=> !tick [*7])
        else $error("divide by eight ticks too often");
    a_capture_irq: assert property (@(posedge CLK_I) disable iff (RST_I)
        (CAPTURE_EVENT_I && ctl.cap_ie) |=> CAPTURE_IRQ_O)
        else $error("capture interrupt missing");
endmodule

// ### sim/tb_timer8_ctrl.sv
// Self-checking bench for the eight-bit timer control and hold registers.
`timescale 1ns/1ns
`include "timer8_map.svh"
module tb_timer8_ctrl;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] bank = 4'h0;
    logic [3:0] idx = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic cap_mode = 1'b0;
    logic cap_ev = 1'b0;
    logic [7:0] rdata;
    logic [7:0] count;
    logic to_irq;
    logic cap_irq;
    logic running;
    logic [7:0] rv;
    logic hit;
    int error_cnt = 0;
    int check_count = 0;
    int p0 = 0;
    int pn;

    timer8_ctrl i_dut (.CLK_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_BANK_I(bank), .REG_INDEX_I(idx), .REG_WDATA_I(wdata),
        .CAPTURE_MODE_I(cap_mode), .CAPTURE_EVENT_I(cap_ev), .REG_RDATA_O(rdata),
        .COUNT_O(count), .TIMEOUT_IRQ_O(to_irq), .CAPTURE_IRQ_O(cap_irq),
        .RUNNING_O(running));

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [3:0] b, input logic [3:0] i, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        bank <= b;
        idx <= i;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [3:0] b, input logic [3:0] i, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        bank <= b;
        idx <= i;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask

    // Counts cycles until the next time-out pulse, giving up after a bounded wait.
    task automatic wait_to(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (to_irq !== 1'b1 && n < 2000);
        if (n >= 2000) check(8'h00, 8'h01, "no time-out pulse");
    endtask

    task automatic pulse_cap(output logic seen);
        @(posedge clk);
        cap_ev <= 1'b1;
        @(posedge clk);
        cap_ev <= 1'b0;
        #1 seen = cap_irq;
        repeat (3) begin
            @(posedge clk);
            #1 seen = seen | cap_irq;
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        reg_rd(`TIMER_BANK_D, `TIMER_OFS_CONTROL, rv);
        check(rv, `TIMER_CONTROL_RESET, "control reset");
        check({7'h00, running}, 8'h00, "running after reset");
        $display("reset test done");
        for (int i = 4; i < 7; i++) reg_wr(`TIMER_BANK_D, 4'(i), 8'(8'hA0 + i));
        reg_wr(4'hC, `TIMER_OFS_LOW_HOLD, 8'h5A);
        for (int i = 4; i < 7; i++) begin
            reg_rd(`TIMER_BANK_D, 4'(i), rv);
            check(rv, 8'(8'hA0 + i), "hold readback");
        end
        reg_rd(4'hC, `TIMER_OFS_LOW_HOLD, rv);
        check(rv, 8'h00, "other bank read");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'h5F);
        reg_rd(`TIMER_BANK_D, `TIMER_OFS_CONTROL, rv);
        check(rv, 8'h5E, "control readback");
        $display("register test done");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_LOW_HOLD, 8'h08);
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'hC0);
        hit = 1'b0;
        repeat (30) begin
            @(posedge clk);
            #1 hit = hit | to_irq;
        end
        check({7'h00, hit}, 8'h00, "masked time-out pulse");
        reg_rd(`TIMER_BANK_D, `TIMER_OFS_CONTROL, rv);
        check(rv, 8'h60, "single pass end");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'h40);
        reg_rd(`TIMER_BANK_D, `TIMER_OFS_CONTROL, rv);
        check(rv, 8'h60, "zero keeps flag");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'h20);
        reg_rd(`TIMER_BANK_D, `TIMER_OFS_CONTROL, rv);
        check(rv, 8'h00, "one clears flag");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'hC2);
        @(posedge clk);
        #1 check({7'h00, running}, 8'h01, "running after start");
        wait_to(pn);
        $display("single pass test done");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_LOW_HOLD, 8'h03);
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_HIGH_HOLD, 8'h03);
        for (int s = 0; s < 4; s++) begin
            reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'(8'h82 | (s << 3)));
            wait_to(pn);
            wait_to(pn);
            wait_to(pn);
            if (s == 0) p0 = pn;
            check(8'(pn), 8'(p0 << s), "time-out period");
        end
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        #1 rv = count;
        repeat (10) @(posedge clk);
        #1 check(count, rv, "count held when stopped");
        $display("prescale test done");
        pulse_cap(hit);
        check({7'h00, hit}, 8'h00, "capture masked");
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'h04);
        pulse_cap(hit);
        check({7'h00, hit}, 8'h01, "capture raised");
        cap_mode <= 1'b1;
        reg_wr(`TIMER_BANK_D, `TIMER_OFS_CONTROL, 8'h86);
        wait_to(pn);
        hit = 1'b0;
        repeat (4) begin
            @(posedge clk);
            #1 hit = hit | (count === 8'hFF);
        end
        check({7'h00, hit}, 8'h01, "capture resumes from all ones");
        // A capture event while running reloads all ones; three ticks later the copy shows FD.
        pulse_cap(hit);
        check({7'h00, hit}, 8'h01, "capture raised while counting");
        check(count, 8'hFD, "capture event reloads all ones");
        $display("capture test done");
        finish_test();
    end
endmodule
